// >>> src/spwd_pkg.sv
package spwd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_WAKE_STATUS = 8'hb3;
  localparam logic [7:0] IDX_DELAY_TIME = 8'hb8;
  localparam logic [7:0] IDX_CTRL = 8'hd0;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hd1;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hd2;
  // Status bit positions, shared by interrupt status and mask
  localparam int BIT_RX1 = 0;
  localparam int BIT_RX2 = 1;
  localparam int BIT_BUTTON = 2;
  localparam int BIT_RING = 3;
  localparam int BIT_CIR = 5;
  localparam int BIT_OFF_DONE = 6;
  // Control register fields
  localparam int BIT_DELAY_SEL = 6;
  localparam int BIT_OFF_EN = 7;
  localparam int BIT_PWR_STATE = 4;
  localparam int BIT_COUNTING = 2;
  // Implemented bit masks
  localparam logic [7:0] STATUS_MASK = 8'h2f;
  localparam logic [7:0] DELAY_MASK = 8'h3f;
  localparam logic [7:0] CTRL_WR_MASK = 8'heb;
  localparam logic [7:0] IRQ_MASK_BITS = 8'h6f;
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [5:0] DELAY_RESET = 6'h00;
  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  // Delay timing
  localparam int CLK_HZ = 40_000_000;
  localparam int DELAY_STEP_MS = 500;
  localparam int DELAY_STEP_CYCLES = DELAY_STEP_MS * (CLK_HZ / 1000);
  // Number of synchronised input pins
  localparam int PIN_COUNT = 5;

  // Pin bundle, raw from outside
  typedef struct packed {
    logic buttonN;
    logic cirWake;
    logic ringN;
    logic rx2;
    logic rx1;
  } spwd_pins_t;

  // Shutdown delay state machine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COUNT = 2'b01,
    ST_DONE = 2'b11
  } spwd_state_t;
endpackage : spwd_pkg

// >>> src/spwd_wake_delay.sv
// Notes on behaviour
// - First serial receive pin falling edge sets status bit 0 until read.
// - Second serial receive pin falling edge sets status bit 1 until read.
// - Phone-line indicator event sets status bit 3; enabled, it requests power.
// - Infrared wake event sets status bit 5; enabled, it requests power.
// - Button press sets status bit 2; that latch never raises the power request.
// - Status bit reads one after its event, zero since last clear.
// - Receive, phone and infrared bits are edge latched, held until cleared.
// - Shutdown delay spans 500 ms to 32 s.
// - Field N gives (N+1) times 500 ms, at most 10 ms longer.
// - Delay register resets to the 500 ms setting.
// - Delay starts on button press only with shutdown and delay select enabled.
// - Wake-enable bit set lets its event raise the power request; clear blocks.
// - Button shutdown enable defaults to one after reset.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module spwd_wake_delay #(
  parameter int unsigned STEP_CYCLES = spwd_pkg::DELAY_STEP_CYCLES
) (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [9:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  input wire logic wb_we_i, // Write enable
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  output logic wb_ack_o, // Acknowledge
  input wire spwd_pkg::spwd_pins_t pinsIn, // Raw wake pins
  output logic powerRequestOutN, // Power request, active low
  output logic shutdownPulse, // One cycle at delay expiry
  output logic irq // Level interrupt
);

  localparam int TW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;

  // Synchroniser and edge detection stages
  logic [spwd_pkg::PIN_COUNT-1:0] meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;
  logic [spwd_pkg::PIN_COUNT-1:0] fellEdge, roseEdge;
  logic rx1Edge, rx2Edge, ringEdge, cirEdge, btnEdge;

  // Register state
  logic [7:0] status_q, status_d;
  logic [5:0] delay_q, delay_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] irqSts_q, irqSts_d;
  logic [7:0] irqMask_q, irqMask_d;
  logic powerOn_q, powerOn_d;

  // Bus state
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;

  // Delay engine state
  spwd_pkg::spwd_state_t state_q, state_d;
  logic [TW-1:0] tick_q, tick_d;
  logic [5:0] step_q, step_d;
  logic [5:0] target_q, target_d;
  logic offDone;

  // Decoded bus strobes
  logic access, wrAcc, rdAcc;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] events;
  logic [7:0] rdByte;

  // Two flops per pin, third flop for edge detection
  always_comb begin
    meta_d = pinsIn;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // Per-pin edge detectors
  for (genvar g = 0; g < spwd_pkg::PIN_COUNT; g++) begin : g_edge
    assign fellEdge[g] = prev_q[g] & ~sync_q[g];
    assign roseEdge[g] = ~prev_q[g] & sync_q[g];
  end

  assign rx1Edge = fellEdge[0];
  assign rx2Edge = fellEdge[1];
  assign ringEdge = fellEdge[2];
  assign cirEdge = roseEdge[3];
  assign btnEdge = fellEdge[4];

  // Bus decode: one cycle answer on the byte lane zero
  assign access = wb_cyc_i & wb_stb_i & ~ack_q;
  assign idx = wb_adr_i[9:2];
  assign wrAcc = access & wb_we_i & wb_sel_i[0];
  assign rdAcc = access & ~wb_we_i;
  assign wbyte = wb_dat_i[7:0];

  // Read data mux
  always_comb begin
    unique case (idx)
      spwd_pkg::IDX_WAKE_STATUS: rdByte = status_q & spwd_pkg::STATUS_MASK;
      spwd_pkg::IDX_DELAY_TIME: rdByte = {2'h0, delay_q};
      spwd_pkg::IDX_CTRL: begin
        rdByte = ctrl_q & spwd_pkg::CTRL_WR_MASK;
        rdByte[spwd_pkg::BIT_PWR_STATE] = powerOn_q;
        rdByte[spwd_pkg::BIT_COUNTING] = (state_q == spwd_pkg::ST_COUNT);
      end
      spwd_pkg::IDX_IRQ_STATUS: rdByte = irqSts_q;
      spwd_pkg::IDX_IRQ_MASK: rdByte = irqMask_q;
      default: rdByte = 8'h00;
    endcase
  end

  // Bus answer
  always_comb begin
    ack_d = access;
    rdat_d = rdat_q;
    if (rdAcc) begin
      rdat_d = {24'h000000, rdByte};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Hardware events in status layout
  always_comb begin
    events = 8'h00;
    events[spwd_pkg::BIT_RX1] = rx1Edge;
    events[spwd_pkg::BIT_RX2] = rx2Edge;
    events[spwd_pkg::BIT_BUTTON] = btnEdge;
    events[spwd_pkg::BIT_RING] = ringEdge;
    events[spwd_pkg::BIT_CIR] = cirEdge;
    events[spwd_pkg::BIT_OFF_DONE] = offDone;
  end

  // Register file next state
  always_comb begin
    status_d = status_q;
    delay_d = delay_q;
    ctrl_d = ctrl_q;
    irqSts_d = irqSts_q;
    irqMask_d = irqMask_q;
    if (rdAcc && idx == spwd_pkg::IDX_WAKE_STATUS) begin
      status_d = 8'h00;
    end
    status_d = (status_d | events) & spwd_pkg::STATUS_MASK;
    if (wrAcc) begin
      unique case (idx)
        spwd_pkg::IDX_DELAY_TIME: delay_d = wbyte[5:0];
        spwd_pkg::IDX_CTRL: ctrl_d = wbyte & spwd_pkg::CTRL_WR_MASK;
        spwd_pkg::IDX_IRQ_STATUS: irqSts_d = irqSts_q & ~wbyte;
        spwd_pkg::IDX_IRQ_MASK: irqMask_d = wbyte & spwd_pkg::IRQ_MASK_BITS;
        default: ;
      endcase
    end
    // Interrupt set wins over write-one clear
    irqSts_d = (irqSts_d | events) & spwd_pkg::IRQ_MASK_BITS;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_q <= spwd_pkg::STATUS_RESET;
      delay_q <= spwd_pkg::DELAY_RESET;
      ctrl_q <= spwd_pkg::CTRL_RESET;
      irqSts_q <= spwd_pkg::IRQ_RESET;
      irqMask_q <= spwd_pkg::IRQ_RESET;
    end else begin
      status_q <= status_d;
      delay_q <= delay_d;
      ctrl_q <= ctrl_d;
      irqSts_q <= irqSts_d;
      irqMask_q <= irqMask_d;
    end
  end

  assign irq = |(irqSts_q & irqMask_q);

  // Shutdown delay engine
  always_comb begin
    state_d = state_q;
    tick_d = tick_q;
    step_d = step_q;
    target_d = target_q;
    offDone = 1'b0;
    unique case (state_q)
      spwd_pkg::ST_IDLE: begin
        if (btnEdge && ctrl_q[spwd_pkg::BIT_OFF_EN] && ctrl_q[spwd_pkg::BIT_DELAY_SEL] && powerOn_q) begin
          state_d = spwd_pkg::ST_COUNT;
          tick_d = '0;
          step_d = 6'h00;
          target_d = delay_q;
        end
      end
      spwd_pkg::ST_COUNT: begin
        if (tick_q == TW'(STEP_CYCLES - 1)) begin
          tick_d = '0;
          if (step_q == target_q) begin
            state_d = spwd_pkg::ST_DONE;
          end else begin
            step_d = step_q + 6'h01;
          end
        end else begin
          tick_d = tick_q + TW'(1);
        end
      end
      spwd_pkg::ST_DONE: begin
        offDone = 1'b1;
        state_d = spwd_pkg::ST_IDLE;
      end
      default: state_d = spwd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= spwd_pkg::ST_IDLE;
      tick_q <= '0;
      step_q <= 6'h00;
      target_q <= 6'h00;
    end else begin
      state_q <= state_d;
      tick_q <= tick_d;
      step_q <= step_d;
      target_q <= target_d;
    end
  end

  // Power request: enabled wake edges raise it, delay expiry drops it
  always_comb begin
    powerOn_d = powerOn_q;
    if (offDone) begin
      powerOn_d = 1'b0;
    end
    // gated by wake enables; button latch not used
    if ((events & ctrl_q & spwd_pkg::STATUS_MASK & ~8'h04) != 8'h00) begin
      powerOn_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      powerOn_q <= 1'b0;
    end else begin
      powerOn_q <= powerOn_d;
    end
  end

  assign powerRequestOutN = ~powerOn_q;
  assign shutdownPulse = offDone;

  // Helper: cycles spent counting
  logic [31:0] elapsed_q;
  always_ff @(posedge ref_clk) begin
    if (rst || state_q != spwd_pkg::ST_COUNT) begin
      elapsed_q <= 32'h00000000;
    end else begin
      elapsed_q <= elapsed_q + 32'h00000001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_RX1_SET: assert property (rx1Edge |=> status_q[0])
    else $error("rx1 edge not latched");
  AST_RX2_SET: assert property (rx2Edge |=> status_q[1] ##1 status_q[1] || $past(rdAcc))
    else $error("rx2 edge not held");
  AST_RING_SET: assert property (ringEdge && ctrl_q[3] |=> status_q[3] && powerOn_q)
    else $error("ring event not latched");
  AST_CIR_SET: assert property (cirEdge && ctrl_q[5] |=> status_q[5] && !powerRequestOutN)
    else $error("infrared event not latched");
  AST_BTN_NO_POWER: assert property (btnEdge && !ctrl_q[7] && events[6:0] == 7'h04 |=> $stable(powerOn_q))
    else $error("button latch touched power");
  AST_READ_CLEARS: assert property (rdAcc && idx == spwd_pkg::IDX_WAKE_STATUS && events == 8'h00 |=>
    status_q == 8'h00)
    else $error("status not cleared by read");
  AST_HOLD: assert property (status_q[3] && !rdAcc |=> status_q[3])
    else $error("status bit lost without read");
  AST_DURATION: assert property (state_q == spwd_pkg::ST_COUNT && state_d == spwd_pkg::ST_DONE |->
    elapsed_q + 32'h00000001 == ({26'h0, target_q} + 32'h00000001) * 32'(STEP_CYCLES))
    else $error("delay length wrong");
  AST_RANGE: assert property (state_q == spwd_pkg::ST_COUNT |-> step_q <= target_q)
    else $error("delay step out of range");
  AST_DELAY_RESET: assert property (disable iff (1'b0) rst |=> delay_q == 6'h00 && ctrl_q[7])
    else $error("reset values wrong");
  AST_START: assert property (state_q == spwd_pkg::ST_IDLE && !(ctrl_q[7] && ctrl_q[6]) |=>
    state_q != spwd_pkg::ST_COUNT)
    else $error("delay started while disabled");
  AST_WAKE_GATE: assert property (!powerOn_q && (events & ctrl_q & 8'h2b) == 8'h00 |=> !powerOn_q)
    else $error("disabled event raised power");
  AST_RESERVED: assert property (rdAcc && (idx == spwd_pkg::IDX_WAKE_STATUS ||
    idx == spwd_pkg::IDX_DELAY_TIME) |=> wb_ack_o && wb_dat_o[7:6] == 2'b00)
    else $error("reserved bits nonzero");

  COV_WAKE: cover property (ringEdge && ctrl_q[3] ##1 powerOn_q);
  COV_DELAY: cover property (state_q == spwd_pkg::ST_COUNT ##1 state_q == spwd_pkg::ST_DONE);
  COV_CLEAR_RACE: cover property (rdAcc && idx == spwd_pkg::IDX_WAKE_STATUS && rx1Edge);
  COV_IRQ: cover property (irq);

endmodule : spwd_wake_delay

// >>> test/spwd_pin_model.sv
`timescale 1ns/1ps
// Wake-source pins: each fire bit drives its pin active for four cycles
module spwd_pin_model (
  input wire logic ref_clk, // Bench clock
  input wire logic [4:0] fire, // One-cycle request per pin
  output spwd_pkg::spwd_pins_t pins // Pin levels toward the block
);
  int holdCnt[5];
  logic [4:0] act;
  // Hold timers, one per pin
  always @(posedge ref_clk) begin
    for (int k = 0; k < 5; k++) begin
      if (fire[k]) begin
        holdCnt[k] <= 4;
      end else if (holdCnt[k] > 0) begin
        holdCnt[k] <= holdCnt[k] - 1;
      end
    end
  end
  // Active levels: infrared high, all others low
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      act[k] = (holdCnt[k] > 0);
    end
  end
  assign pins = spwd_pkg::spwd_pins_t'(act ^ 5'h17);
endmodule : spwd_pin_model

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int STEP = 8;
  logic ref_clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, pwrN, offPulse, irq;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0, rdat, r;
  logic [3:0] sel = 4'h0;
  logic [4:0] fire = 5'h00;
  spwd_pkg::spwd_pins_t pins;
  int miscompares = 0, checks = 0, pulses = 0, expSt, expIrq, expPwr, n, cnt, v;
  int stBit[5] = '{0, 1, 3, 5, 2};
  spwd_wake_delay #(.STEP_CYCLES(STEP)) spwd_wake_delay_inst (.ref_clk(ref_clk), .rst(rst),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .pinsIn(pins),
    .powerRequestOutN(pwrN), .shutdownPulse(offPulse), .irq(irq));
  spwd_pin_model spwd_pin_model_inst (.ref_clk(ref_clk), .fire(fire), .pins(pins));
  // Clock, 25 ns period
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Expiry pulse counter
  always @(posedge ref_clk) begin
    if (offPulse === 1'b1) pulses++;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    sel <= 4'h1;
    // Wait for ack; only the watchdog ends a hang
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    r = rdat;
    chk("upper", {8'h00, r[31:8]}, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic rd(input string what, input logic [7:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(what, r, exp);
  endtask : rd
  // One event on pin k, with model update
  task automatic ev(input int k, input int ctrl);
    @(posedge ref_clk);
    fire <= 5'(1 << k);
    @(posedge ref_clk);
    fire <= 5'h00;
    repeat (10) @(posedge ref_clk);
    expSt |= 1 << stBit[k];
    expIrq |= 1 << stBit[k];
    if (k != 4 && ctrl[stBit[k]]) expPwr = 1;
  endtask : ev
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h32e1));
    expSt = 0;
    expIrq = 0;
    expPwr = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd("status", spwd_pkg::IDX_WAKE_STATUS, 0);
    rd("delay", spwd_pkg::IDX_DELAY_TIME, 0);
    rd("ctrl", spwd_pkg::IDX_CTRL, 32'h80);
    rd("unmapped", 8'h10, 0);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'hff : $urandom % 256;
      wb(1'b1, spwd_pkg::IDX_DELAY_TIME, 8'(v));
      rd("delay", spwd_pkg::IDX_DELAY_TIME, v & 8'h3f);
    end
    wb(1'b1, spwd_pkg::IDX_WAKE_STATUS, 8'hff);
    rd("status", spwd_pkg::IDX_WAKE_STATUS, 0);
    wb(1'b1, spwd_pkg::IDX_CTRL, 8'h00);
    for (int k = 0; k < 5; k++) begin
      ev(k, 0);
      rd("status", spwd_pkg::IDX_WAKE_STATUS, expSt);
      expSt = 0;
      rd("status", spwd_pkg::IDX_WAKE_STATUS, 0);
      chk("power", pwrN, !expPwr);
    end
    chk("irq", irq, 0);
    wb(1'b1, spwd_pkg::IDX_IRQ_MASK, 8'h08);
    chk("irq", irq, 1);
    rd("irqmask", spwd_pkg::IDX_IRQ_MASK, 32'h08);
    wb(1'b1, spwd_pkg::IDX_IRQ_STATUS, 8'h08);
    expIrq = expIrq & 8'h27;
    chk("irq", irq, 0);
    rd("irqst", spwd_pkg::IDX_IRQ_STATUS, expIrq);
    wb(1'b1, spwd_pkg::IDX_IRQ_STATUS, 8'(expIrq));
    expIrq = 0;
    wb(1'b1, spwd_pkg::IDX_CTRL, 8'h88);
    ev(2, 8'h88);
    chk("power", pwrN, !expPwr);
    ev(4, 8'h88);
    chk("pulses", pulses, 0);
    chk("power", pwrN, 0);
    n = $urandom % 4;
    wb(1'b1, spwd_pkg::IDX_DELAY_TIME, 8'(n));
    wb(1'b1, spwd_pkg::IDX_CTRL, 8'hc8);
    @(posedge ref_clk);
    fire <= 5'h10;
    cnt = 0;
    @(posedge ref_clk);
    fire <= 5'h00;
    while (offPulse !== 1'b1 && cnt < 500) begin
      @(posedge ref_clk);
      cnt++;
    end
    chk("span", cnt >= (n + 1) * STEP && cnt <= (n + 1) * STEP + 8, 1);
    repeat (2) @(posedge ref_clk);
    chk("power", pwrN, 1);
    chk("pulses", pulses, 1);
    expIrq |= 8'h44;
    rd("irqst", spwd_pkg::IDX_IRQ_STATUS, expIrq);
    rd("status", spwd_pkg::IDX_WAKE_STATUS, 32'h0c);
    // Infrared wake with its enable set, after power was dropped
    expSt = 0;
    expPwr = 0;
    wb(1'b1, spwd_pkg::IDX_CTRL, 8'h23);
    ev(3, 8'h23);
    chk("power", pwrN, !expPwr);
    rd("status", spwd_pkg::IDX_WAKE_STATUS, expSt);
    rd("ctrl", spwd_pkg::IDX_CTRL, 32'h33);
    end_sim();
  end
endmodule : testbench
